// *** design/sar_adc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  if (W < 1 || DEPTH < 2) begin : g_chk
    $error("sar_fifo: unsupported W or DEPTH");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    valid;
    logic                    ready;
  } sar_fifo_state_type;

  sar_fifo_state_type st_r;
  sar_fifo_state_type st_nxt;
  logic               push;
  logic               pop;
  logic [CW-1:0]      wr_idx;

  // head stays at slot zero so the output is a flop
  always_comb begin
    st_nxt = st_r;
    push   = in_valid & st_r.ready;
    pop    = st_r.valid & out_ready;
    wr_idx = st_r.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_nxt.mem[i] = st_r.mem[i+1];
      end
    end
    if (push) begin
      st_nxt.mem[wr_idx] = in_data;
    end
    st_nxt.cnt   = st_r.cnt + CW'(push) - CW'(pop);
    st_nxt.valid = (st_nxt.cnt != '0);
    st_nxt.ready = (st_nxt.cnt != CW'(DEPTH));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.ready <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = st_r.ready;
  assign out_valid = st_r.valid;
  assign out_data  = st_r.mem[0];

endmodule

module sar_adc_host
  import sar_pkg::*;
#(
  parameter int HALF_CLKS   = SCLK_HALF_MIN_CLKS,
  parameter int WAKE_CYCLES = WAKE_CLKS,
  parameter int DEPTH       = FIFO_DEPTH,
  parameter int RES         = RES_BITS
) (
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      ce,
  sar_link_if.host       link,
  input  wire logic      conv_en,
  input  wire logic      abort,
  input  wire logic      shutdown_req,
  output logic           rd_valid,
  input  wire logic      rd_ready,
  output logic [RES-1:0] rd_data,
  output logic           busy,
  output logic           waking
);

  localparam int TW = 20;
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS);

  // divider may not go below the clock limit
  if (HALF_CLKS < SCLK_HALF_MIN_CLKS || WAKE_CYCLES < 1 || WAKE_CYCLES >= 2**TW || RES != RES_BITS)
  begin : g_chk
    $error("sar_adc_host: unsupported parameter");
  end

  typedef enum logic [2:0] {
    H_OFF,
    H_WAKE,
    H_IDLE,
    H_LOW,
    H_HIGH,
    H_STORE,
    H_GAP
  } sar_host_st_type;

  typedef struct packed {
    sar_host_st_type       state;
    logic [TW-1:0]         timer;
    logic [4:0]            bits;
    logic [FRAME_BITS-1:0] shift;
    logic [1:0]            din_sy;
    logic                  sel_n;
    logic                  sclk;
    logic                  pdn;
    logic                  busy;
    logic                  waking;
    logic                  push;
    logic [RES-1:0]        push_data;
  } sar_host_reg_type;

  sar_host_reg_type st_r;
  sar_host_reg_type st_nxt;
  logic             fifo_ready;
  logic             tick;

  function automatic logic [TW-1:0] load(input int cycles);
    return TW'(cycles - 1);
  endfunction

  always_comb begin
    st_nxt        = st_r;
    st_nxt.din_sy = {st_r.din_sy[0], link.dout_line};
    st_nxt.push   = 1'b0;
    tick          = (st_r.timer == '0);
    if (!tick) begin
      st_nxt.timer = st_r.timer - TW'(1);
    end
    case (st_r.state)
      H_OFF: begin
        st_nxt.pdn = 1'b0;
        if (!shutdown_req) begin
          st_nxt.pdn    = 1'b1;
          st_nxt.waking = 1'b1;
          st_nxt.timer  = load(WAKE_CYCLES);
          st_nxt.state  = H_WAKE;
        end
      end
      H_WAKE: begin
        if (tick) begin
          st_nxt.waking = 1'b0;
          st_nxt.state  = H_IDLE;
        end
      end
      H_IDLE: begin
        if (shutdown_req) begin
          st_nxt.pdn   = 1'b0;
          st_nxt.state = H_OFF;
        end else if (conv_en && fifo_ready) begin
          st_nxt.sel_n = 1'b0;
          st_nxt.sclk  = 1'b0;
          st_nxt.bits  = 5'h00;
          st_nxt.busy  = 1'b1;
          st_nxt.timer = load(HALF_CLKS);
          st_nxt.state = H_LOW;
        end
      end
      H_LOW: begin
        if (tick) begin
          st_nxt.sclk  = 1'b1;
          st_nxt.shift = {st_r.shift[FRAME_BITS-2:0], st_r.din_sy[1]};
          st_nxt.bits  = st_r.bits + 5'h01;
          st_nxt.timer = load(HALF_CLKS);
          st_nxt.state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          st_nxt.sclk  = 1'b0;
          st_nxt.timer = load(HALF_CLKS);
          st_nxt.state = (st_r.bits == LAST_BIT) ? H_STORE : H_LOW;
        end
      end
      H_STORE: begin
        st_nxt.sel_n = 1'b1;
        st_nxt.busy  = 1'b0;
        st_nxt.push  = 1'b1;
        // drop three lead zeros, trailing zero
        st_nxt.push_data = st_r.shift[FRAME_BITS-LEAD_ZEROS-1 -: RES];
        st_nxt.timer = load(SELECT_HIGH_CLKS);
        st_nxt.state = H_GAP;
      end
      H_GAP: begin
        if (tick) begin
          st_nxt.state = H_IDLE;
        end
      end
      default: begin
        st_nxt.state = H_IDLE;
      end
    endcase
    if (abort && (st_r.state == H_LOW || st_r.state == H_HIGH)) begin
      st_nxt.sel_n = 1'b1;
      st_nxt.sclk  = 1'b0;
      st_nxt.busy  = 1'b0;
      st_nxt.timer = load(ACQ_CLKS);
      st_nxt.state = H_GAP;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.state  <= H_IDLE;
      st_r.sel_n  <= 1'b1;
      st_r.pdn    <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // starts wait for room, so a push is never refused
  sar_fifo #(
    .W     (RES),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (st_r.push),
    .in_ready  (fifo_ready),
    .in_data   (st_r.push_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign link.sel_n        = st_r.sel_n;
  assign link.sclk         = st_r.sclk;
  assign link.power_down_n = st_r.pdn;
  assign busy              = st_r.busy;
  assign waking            = st_r.waking;

endmodule
`default_nettype wire

// *** design/sar_pkg.sv ***
package sar_pkg;

  // result and frame shape, FIFO depth
  localparam int RES_BITS       = 12;
  localparam int LEAD_ZEROS     = 3;
  localparam int MIN_FRAME_CLKS = 15;
  localparam int BYTE_BITS      = 8;
  localparam int FRAME_BITS     = 2 * BYTE_BITS;
  localparam int FIFO_DEPTH     = 8;

  // clock rates
  localparam int MCLK_PERIOD_NS = 4;
  localparam int SCLK_MAX_KHZ   = 4800;
  // half period of the fastest legal serial clock, rounded up
  localparam int SCLK_HALF_MIN_CLKS =
    (1000000 + 2 * SCLK_MAX_KHZ * MCLK_PERIOD_NS - 1) / (2 * SCLK_MAX_KHZ * MCLK_PERIOD_NS);

  // timing figures, least times rounded up to cycles
  localparam int ACQUISITION_TIME_NS   = 625;
  localparam int ACQ_CLKS              = (ACQUISITION_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SELECT_HIGH_MIN_TIME_NS = 50;
  localparam int SELECT_HIGH_CLKS      = (SELECT_HIGH_MIN_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int WAKE_DELAY_US         = 2500;
  localparam int WAKE_CLKS             = (WAKE_DELAY_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  localparam logic [RES_BITS-1:0] CODE_FULL = 12'hFFF;

  // input given in half-code steps; transitions fall midway between codes
  function automatic logic [RES_BITS-1:0] sar_code(input logic [RES_BITS:0] ain_half);
    logic [RES_BITS+1:0] rounded;
    rounded = {1'b0, ain_half} + 14'h0001;
    if (rounded[RES_BITS+1:1] > {1'b0, CODE_FULL}) begin
      return CODE_FULL;
    end
    return rounded[RES_BITS:1];
  endfunction

endpackage

// *** design/sar_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface sar_link_if;
  logic sel_n;
  logic sclk;
  logic power_down_n;
  logic dout_o;
  logic dout_oe;
  logic dout_line;

  // undriven data line reads low
  assign dout_line = dout_oe ? dout_o : 1'b0;

  modport dev (
    input  sel_n,
    input  sclk,
    input  power_down_n,
    output dout_o,
    output dout_oe
  );

  modport host (
    output sel_n,
    output sclk,
    output power_down_n,
    input  dout_line
  );
endinterface
`default_nettype wire

// *** design/sar_adc_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_adc_dev
  import sar_pkg::*;
#(
  parameter int RES  = RES_BITS,
  parameter int LEAD = LEAD_ZEROS
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           ce,
  sar_link_if.dev             link,
  input  wire logic [RES:0]   ain_half,
  output logic                busy,
  output logic                ref_off,
  output logic [RES-1:0]      held_code
);

  localparam logic [4:0] LAST_RISE = 5'(LEAD + RES - 1);
  localparam logic [4:0] FIRST_BIT = 5'(LEAD);

  if (RES != RES_BITS || LEAD < 1 || LEAD + RES > 31) begin : g_chk
    $error("sar_adc_dev: unsupported RES or LEAD");
  end

  typedef struct packed {
    logic [1:0]     sel_sy;
    logic [1:0]     clk_sy;
    logic [1:0]     pd_sy;
    logic           sel_q;
    logic           clk_q;
    logic [4:0]     rises;
    logic [RES-1:0] shreg;
    logic [RES-1:0] held;
    logic           dout;
    logic           oe;
    logic           busy;
    logic           ref_off;
  } sar_dev_state_type;

  sar_dev_state_type st_r;
  sar_dev_state_type st_nxt;
  logic [4:0]        rise_num;

  always_comb begin
    st_nxt        = st_r;
    rise_num      = st_r.rises + 5'h01;
    st_nxt.sel_sy = {st_r.sel_sy[0], link.sel_n};
    st_nxt.clk_sy = {st_r.clk_sy[0], link.sclk};
    st_nxt.pd_sy  = {st_r.pd_sy[0], link.power_down_n};
    st_nxt.sel_q  = st_r.sel_sy[1];
    st_nxt.clk_q  = st_r.clk_sy[1];
    // low input shuts down, reference off
    st_nxt.ref_off = ~st_r.pd_sy[1];
    if (st_r.sel_sy[1]) begin
      st_nxt.oe   = 1'b0;
      st_nxt.dout = 1'b0;
      st_nxt.rises = 5'h00;
      st_nxt.shreg = '0;
      st_nxt.busy  = 1'b0;
    end else if (st_r.sel_q) begin
      st_nxt.oe    = 1'b1;
      st_nxt.dout  = 1'b0;
      st_nxt.rises = 5'h00;
      st_nxt.busy  = ~st_r.ref_off;
      st_nxt.shreg = st_r.ref_off ? '0 : sar_code(ain_half);
      st_nxt.held  = st_r.ref_off ? '0 : sar_code(ain_half);
    end else if (st_r.clk_sy[1] && !st_r.clk_q) begin
      if (st_r.rises != LAST_RISE + 5'h01) begin
        st_nxt.rises = rise_num;
      end
      if (rise_num >= FIRST_BIT) begin
        st_nxt.dout  = st_r.shreg[RES-1];
        st_nxt.shreg = {st_r.shreg[RES-2:0], 1'b0};
      end else begin
        st_nxt.dout = 1'b0;
      end
      if (rise_num >= LAST_RISE) begin
        st_nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // select and power-down idle high, so no false edge after reset
      st_r        <= '0;
      st_r.sel_sy <= 2'h3;
      st_r.sel_q  <= 1'b1;
      st_r.pd_sy  <= 2'h3;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign link.dout_o  = st_r.dout;
  assign link.dout_oe = st_r.oe;
  assign busy         = st_r.busy;
  assign ref_off      = st_r.ref_off;
  assign held_code    = st_r.held;

endmodule
`default_nettype wire

// *** bench/sar_link_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_link_properties
  import sar_pkg::*;
#(
  parameter int WAKE_MIN = WAKE_CLKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic power_down_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout_line
);
  logic        sclk_q;
  logic        rise;
  logic        short_r;
  logic [4:0]  n_rise;
  logic [9:0]  hi_cnt;
  logic [9:0]  run;
  logic [19:0] wake_cnt;

  assign rise = sclk & ~sclk_q;

  // hi_cnt, run and wake_cnt saturate so idle after reset never looks short
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_q  <= 1'b0;
      short_r <= 1'b0;
      n_rise  <= 5'h00;
      hi_cnt  <= 10'h3FF;
      run     <= 10'h3FF;
      wake_cnt <= 20'hFFFFF;
    end else begin
      sclk_q  <= sclk;
      n_rise  <= sel_n ? 5'h00 : n_rise + 5'(rise);
      short_r <= sel_n ? short_r : (n_rise < 5'h10);
      hi_cnt  <= !sel_n ? 10'h000 : hi_cnt + 10'(hi_cnt != 10'h3FF);
      run     <= (sclk != sclk_q) ? 10'h001 : run + 10'(run != 10'h3FF);
      wake_cnt <= !power_down_n ? 20'h00000 : wake_cnt + 20'(wake_cnt != 20'hFFFFF);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_oe_on_fall: assert property ($fell(sel_n) |-> ##3 (dout_oe && !dout_o))
    else $error("output not driven low after select");
  a_oe_off_rise: assert property ($rose(sel_n) |-> ##3 !dout_oe)
    else $error("output not released after select");
  a_idle_released: assert property (sel_n [*4] |-> !dout_oe)
    else $error("output driven while deselected");
  a_bit_on_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |-> $past(rise, 3))
    else $error("data changed without clock rise");
  a_lead_zeros: assert property (dout_oe && $past(n_rise, 2) < 5'h03 |-> !dout_o)
    else $error("leading bit not zero");
  a_trail_zeros: assert property (dout_oe && $past(n_rise, 2) > 5'h0E |-> !dout_line)
    else $error("trailing bit not zero");
  a_clock_idle: assert property (sel_n |-> !sclk)
    else $error("clock high while deselected");
  a_half_min: assert property (!sel_n && sclk != sclk_q |-> run >= SCLK_HALF_MIN_CLKS)
    else $error("clock phase too short");
  a_gap_min: assert property ($fell(sel_n) |-> hi_cnt >= (short_r ? ACQ_CLKS : SELECT_HIGH_CLKS))
    else $error("select high time too short");
  a_wake_wait: assert property ($fell(sel_n) |-> wake_cnt >= 20'(WAKE_MIN))
    else $error("conversion started during wake delay");
  a_down_idle: assert property (!power_down_n |-> sel_n)
    else $error("select low while powered down");
endmodule
`default_nettype wire

// *** bench/sar_adc_serial_readout_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_adc_serial_readout_bench
  import sar_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst;
  logic        ce;
  logic        conv_en;
  logic        abort;
  logic        shutdown_req;
  logic        rd_ready;
  logic        rd_valid;
  logic        h_busy;
  logic        waking;
  logic        d_busy;
  logic        ref_off;
  logic [11:0] rd_data;
  logic [11:0] held;
  logic [11:0] ef;
  logic [12:0] ain;
  logic [15:0] sh;
  logic        sq = 1'b0;
  logic        sp = 1'b1;
  int          nb = 0;
  int          cyc = 0;
  int          n_fail;
  int          compares;
  logic [12:0] tab [9] = '{13'h0000, 13'h0001, 13'h0002, 13'h1FFD, 13'h1FFF,
                           13'h0AAA, 13'h1555, 13'h0FFE, 13'h1001};
  localparam int WAKE_SIM = 20;

  sar_link_if lk();

  sar_adc_dev i_sar_adc_dev (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .link      (lk.dev),
    .ain_half  (ain),
    .busy      (d_busy),
    .ref_off   (ref_off),
    .held_code (held)
  );

  sar_adc_host #(.WAKE_CYCLES(WAKE_SIM)) i_sar_adc_host (
    .mclk         (mclk),
    .rst          (rst),
    .ce           (ce),
    .link         (lk.host),
    .conv_en      (conv_en),
    .abort        (abort),
    .shutdown_req (shutdown_req),
    .rd_valid     (rd_valid),
    .rd_ready     (rd_ready),
    .rd_data      (rd_data),
    .busy         (h_busy),
    .waking       (waking)
  );

  sar_link_properties #(.WAKE_MIN(WAKE_SIM)) i_chk (
    .mclk         (mclk),
    .rst          (rst),
    .sel_n        (lk.sel_n),
    .sclk         (lk.sclk),
    .power_down_n (lk.power_down_n),
    .dout_o       (lk.dout_o),
    .dout_oe      (lk.dout_oe),
    .dout_line    (lk.dout_line)
  );

  always #2 mclk = ~mclk;

  function automatic logic [11:0] code(input logic [12:0] a);
    logic [13:0] t;
    t = ({1'b0, a} + 14'h0001) >> 1;
    return (t > 14'h0FFF) ? 12'hFFF : t[11:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task summarize;
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic start(input logic [12:0] a);
    ain <= a;
    conv_en <= 1'b1;
    @(posedge mclk iff h_busy);
    conv_en <= 1'b0;
    @(posedge mclk iff !h_busy);
  endtask

  task automatic pop(input logic [11:0] e);
    rd_ready <= 1'b1;
    @(posedge mclk iff rd_valid);
    chk("rd_data", {4'h0, e}, {4'h0, rd_data});
    rd_ready <= 1'b0;
    @(posedge mclk);
  endtask

  // wire-side capture, first bit sampled on the first rise
  always @(posedge mclk) begin
    sq <= lk.sclk;
    sp <= lk.sel_n;
    if (!lk.sel_n && sp) ef <= code(ain);
    if (!lk.sel_n && lk.sclk && !sq) begin
      sh <= {sh[14:0], lk.dout_line};
      nb <= nb + 1;
    end
    if (lk.sel_n) begin
      if (nb == 16) chk("frame", {3'b000, ef, 1'b0}, sh);
      if (nb == 16) chk("dev busy", 16'h0000, {15'h0, d_busy});
      nb <= 0;
    end
  end

  // whole run is near 12400 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    conv_en = 1'b0;
    abort = 1'b0;
    shutdown_req = 1'b0;
    rd_ready = 1'b0;
    ain = 13'h0000;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) start(tab[i]);
    ain <= tab[8];
    conv_en <= 1'b1;
    repeat (2000) @(posedge mclk);
    chk("busy when full", 16'h0000, {15'h0, h_busy});
    for (int i = 0; i < 9; i++) begin
      pop(code(tab[i]));
      if (i == 0) begin
        @(posedge mclk iff h_busy);
        conv_en <= 1'b0;
      end
    end
    ain <= tab[5];
    conv_en <= 1'b1;
    @(posedge mclk iff h_busy);
    conv_en <= 1'b0;
    repeat (200) @(posedge mclk);
    chk("dev busy", 16'h0001, {15'h0, d_busy});
    abort <= 1'b1;
    // input moves after the fall, held code must not follow
    ain <= tab[6];
    @(posedge mclk iff !h_busy);
    abort <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("dout_oe", 16'h0000, {15'h0, lk.dout_oe});
    chk("held_code", {4'h0, code(tab[5])}, {4'h0, held});
    chk("rd_valid", 16'h0000, {15'h0, rd_valid});
    // frozen host must not finish the acquisition wait
    ce <= 1'b0;
    conv_en <= 1'b1;
    repeat (300) @(posedge mclk);
    chk("frozen busy", 16'h0000, {15'h0, h_busy});
    ce <= 1'b1;
    start(tab[6]);
    pop(code(tab[6]));
    shutdown_req <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("power_down_n", 16'h0000, {15'h0, lk.power_down_n});
    chk("ref_off", 16'h0001, {15'h0, ref_off});
    shutdown_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("waking", 16'h0001, {15'h0, waking});
    start(tab[7]);
    pop(code(tab[7]));
    summarize();
  end
endmodule
`default_nettype wire
